// *** rtcam_top.sv ***
// Behaviour
// - Bit 7 low enables field; reset disabled
// - Minute match holds BCD tens, units
// - Hour match bit 6 unused, meridiem layout
// - Hour layout follows 12/24 hour selection
// - Day match bit 6 unused, BCD day
// - Weekday match bits 6-3 unused
// - Flag sets when enabled fields first match
// - Disabled fields ignored in comparison
// - Flag holds until cleared; new match resets
// - Interrupt pin follows flag when enabled
// - Flags at bits 5, 3, 2
// - Flag write ANDs; zero clears, one keeps
// - Three-bit square wave code, bits 7-3 unused
// - Code decode to frequencies; 111 low
// - Output on at reset, code 000
// - Divided frequencies have even duty
// - Stop forces codes 011-110 low
`timescale 1ns/1ps
module rtcam_top
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Register access
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Running calendar counters
   input wire logic [7:0] cur_minute,
   input wire logic [7:0] cur_hour,
   input wire logic [7:0] cur_day,
   input wire logic [7:0] cur_weekday,
   input wire logic hour_mode_12,
   // Events of neighbouring timers
   input wire logic periodic_tick_set,
   input wire logic countdown_event_set,
   // Oscillator chain
   input wire logic osc_edge,
   input wire logic stop_active,
   // Open-drain interrupt pin
   output logic irq_n_lvl,
   output logic irq_n_oe,
   // Open-drain square wave pin
   output logic square_wave_pin_lvl,
   output logic square_wave_pin_oe
);

   logic [7:0] event_flags_control_ff;
   logic [7:0] minute_match_reg_ff;
   logic [7:0] hour_match_reg_ff;
   logic [7:0] day_match_reg_ff;
   logic [7:0] weekday_match_reg_ff;
   logic [7:0] square_wave_select_ff;
   logic [7:0] nxt_event_flags_control;
   logic [7:0] nxt_minute_match_reg;
   logic [7:0] nxt_hour_match_reg;
   logic [7:0] nxt_day_match_reg;
   logic [7:0] nxt_weekday_match_reg;
   logic [7:0] nxt_square_wave_select;
   logic match_prev_ff;
   logic irq_drive_ff;
   logic pin_zero_ff;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic nxt_irq_drive;
   logic minute_match_disable;
   logic hour_match_disable;
   logic day_match_disable;
   logic weekday_match_disable;
   logic any_enabled;
   logic match_now;
   logic match_rise;
   logic wr_flags;
   logic match_event_flag;
   logic match_irq_enable;

   // Masked equality, used for every alarm field
   function automatic logic field_eq(input logic [7:0] a, input logic [7:0] b,
                                     input logic [7:0] mask);
      field_eq = ((a ^ b) & mask) == 8'h00;
   endfunction

   // Address decode for a write strobe
   function automatic logic hit(input logic wr, input logic [7:0] addr,
                                input logic [7:0] ofs);
      hit = wr && (addr == ofs);
   endfunction

   // Hour layout: meridiem plus one tens bit, or two tens bits
   // Both layouts span bits 5:0, so AM and PM of equal digits stay apart
   function automatic logic [7:0] hour_cmp_mask(input logic mode12);
      hour_cmp_mask = mode12 ? rtcam_pkg::CMP_HOUR_12 : rtcam_pkg::CMP_HOUR_24;
   endfunction

   assign minute_match_disable = minute_match_reg_ff[rtcam_pkg::BIT_FIELD_DISABLE];
   assign hour_match_disable = hour_match_reg_ff[rtcam_pkg::BIT_FIELD_DISABLE];
   assign day_match_disable = day_match_reg_ff[rtcam_pkg::BIT_FIELD_DISABLE];
   assign weekday_match_disable = weekday_match_reg_ff[rtcam_pkg::BIT_FIELD_DISABLE];
   assign match_event_flag = event_flags_control_ff[rtcam_pkg::BIT_MATCH_FLAG];
   assign match_irq_enable = event_flags_control_ff[rtcam_pkg::BIT_MATCH_IRQ_EN];
   assign wr_flags = hit(reg_wr, reg_addr, rtcam_pkg::OFS_EVENT_FLAGS);

   // Comparison of enabled fields; rising edge marks the first match
   always_comb
   begin
      any_enabled = !(minute_match_disable && hour_match_disable
                      && day_match_disable && weekday_match_disable);
      match_now = any_enabled
         && (minute_match_disable
             || field_eq(minute_match_reg_ff, cur_minute, rtcam_pkg::CMP_MINUTE))
         && (hour_match_disable
             || field_eq(hour_match_reg_ff, cur_hour, hour_cmp_mask(hour_mode_12)))
         && (day_match_disable
             || field_eq(day_match_reg_ff, cur_day, rtcam_pkg::CMP_DAY))
         && (weekday_match_disable
             || field_eq(weekday_match_reg_ff, cur_weekday, rtcam_pkg::CMP_WEEKDAY));
      match_rise = match_now && !match_prev_ff;
   end

   // Alarm and square wave registers; unused bits never stored
   always_comb
   begin
      nxt_minute_match_reg = minute_match_reg_ff;
      nxt_hour_match_reg = hour_match_reg_ff;
      nxt_day_match_reg = day_match_reg_ff;
      nxt_weekday_match_reg = weekday_match_reg_ff;
      nxt_square_wave_select = square_wave_select_ff;
      if (hit(reg_wr, reg_addr, rtcam_pkg::OFS_MINUTE_MATCH))
      begin
         nxt_minute_match_reg = reg_wdata & rtcam_pkg::MASK_MINUTE;
      end
      if (hit(reg_wr, reg_addr, rtcam_pkg::OFS_HOUR_MATCH))
      begin
         nxt_hour_match_reg = reg_wdata & rtcam_pkg::MASK_HOUR;
      end
      if (hit(reg_wr, reg_addr, rtcam_pkg::OFS_DAY_MATCH))
      begin
         nxt_day_match_reg = reg_wdata & rtcam_pkg::MASK_DAY;
      end
      if (hit(reg_wr, reg_addr, rtcam_pkg::OFS_WEEKDAY_MATCH))
      begin
         nxt_weekday_match_reg = reg_wdata & rtcam_pkg::MASK_WEEKDAY;
      end
      if (hit(reg_wr, reg_addr, rtcam_pkg::OFS_SQUARE_WAVE))
      begin
         nxt_square_wave_select = reg_wdata & rtcam_pkg::MASK_SQUARE_WAVE;
      end
   end

   // Flag register: AND on write; sets applied after it, so a set arriving with a clear survives
   always_comb
   begin
      nxt_event_flags_control = event_flags_control_ff;
      if (wr_flags)
      begin
         nxt_event_flags_control = (reg_wdata & ~rtcam_pkg::MASK_FLAGS)
            | (event_flags_control_ff & reg_wdata & rtcam_pkg::MASK_FLAGS);
      end
      if (match_rise)
      begin
         nxt_event_flags_control[rtcam_pkg::BIT_MATCH_FLAG] = 1'b1;
      end
      if (periodic_tick_set)
      begin
         nxt_event_flags_control[rtcam_pkg::BIT_TICK_FLAG] = 1'b1;
      end
      if (countdown_event_set)
      begin
         nxt_event_flags_control[rtcam_pkg::BIT_COUNTDOWN_FLAG] = 1'b1;
      end
      // Taken from next values so the pin lines up with the flag bit
      nxt_irq_drive = nxt_event_flags_control[rtcam_pkg::BIT_MATCH_FLAG]
         && nxt_event_flags_control[rtcam_pkg::BIT_MATCH_IRQ_EN];
   end

   // Read data, one cycle behind the address; unmapped reads zero
   // A registered read keeps the bus output straight from a flop
   always_comb
   begin
      case (reg_addr)
         rtcam_pkg::OFS_EVENT_FLAGS: nxt_rdata = event_flags_control_ff;
         rtcam_pkg::OFS_MINUTE_MATCH: nxt_rdata = minute_match_reg_ff;
         rtcam_pkg::OFS_HOUR_MATCH: nxt_rdata = hour_match_reg_ff;
         rtcam_pkg::OFS_DAY_MATCH: nxt_rdata = day_match_reg_ff;
         rtcam_pkg::OFS_WEEKDAY_MATCH: nxt_rdata = weekday_match_reg_ff;
         rtcam_pkg::OFS_SQUARE_WAVE: nxt_rdata = square_wave_select_ff;
         default: nxt_rdata = 8'h00;
      endcase
   end

   // State registers; match history starts clear, so a match at reset counts
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         event_flags_control_ff <= rtcam_pkg::RST_EVENT_FLAGS;
         minute_match_reg_ff <= rtcam_pkg::RST_MATCH;
         hour_match_reg_ff <= rtcam_pkg::RST_MATCH;
         day_match_reg_ff <= rtcam_pkg::RST_MATCH;
         weekday_match_reg_ff <= rtcam_pkg::RST_MATCH;
         square_wave_select_ff <= rtcam_pkg::RST_SQUARE_WAVE;
         match_prev_ff <= 1'b0;
         irq_drive_ff <= 1'b0;
         pin_zero_ff <= 1'b0;
         rdata_ff <= 8'h00;
      end
      else
      begin
         event_flags_control_ff <= nxt_event_flags_control;
         minute_match_reg_ff <= nxt_minute_match_reg;
         hour_match_reg_ff <= nxt_hour_match_reg;
         day_match_reg_ff <= nxt_day_match_reg;
         weekday_match_reg_ff <= nxt_weekday_match_reg;
         square_wave_select_ff <= nxt_square_wave_select;
         match_prev_ff <= match_now;
         irq_drive_ff <= nxt_irq_drive;
         pin_zero_ff <= 1'b0;
         rdata_ff <= nxt_rdata;
      end
   end

   // Square wave divider and selector
   rtcam_sqw rtcam_sqw_inst
   (
      .mclk(mclk),
      .rstn(rstn),
      .osc_edge(osc_edge),
      .stop_active(stop_active),
      .code(square_wave_select_ff[2:0]),
      .pin_oe_ff(square_wave_pin_oe)
   );

   // Open-drain pins only ever pull low
   assign reg_rdata = rdata_ff;
   assign irq_n_lvl = pin_zero_ff;
   assign irq_n_oe = irq_drive_ff;
   assign square_wave_pin_lvl = pin_zero_ff;

   // Checks on the alarm path, the flag register and the pins
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   a_flag_on_match: assert property (match_rise |=> match_event_flag)
      else $error("match did not set flag");
   a_flag_holds: assert property (match_event_flag
      && !(wr_flags && !reg_wdata[rtcam_pkg::BIT_MATCH_FLAG]) |=> match_event_flag)
      else $error("flag dropped without clear");
   a_no_reset_while: assert property (!match_event_flag && match_now
      && match_prev_ff |=> !match_event_flag)
      else $error("flag set again without new match");
   a_irq_follows: assert property (irq_n_oe == (match_event_flag && match_irq_enable))
      else $error("interrupt pin not following flag");
   a_pins_pull_only: assert property (!irq_n_lvl && !square_wave_pin_lvl)
      else $error("open drain pin driven high");
   a_write_one_keeps: assert property (wr_flags && reg_wdata[rtcam_pkg::BIT_TICK_FLAG]
      && !event_flags_control_ff[rtcam_pkg::BIT_TICK_FLAG] && !periodic_tick_set
      |=> !event_flags_control_ff[rtcam_pkg::BIT_TICK_FLAG])
      else $error("writing one set a flag");
   a_clear_works: assert property (wr_flags
      && !reg_wdata[rtcam_pkg::BIT_COUNTDOWN_FLAG] && !countdown_event_set
      |=> !event_flags_control_ff[rtcam_pkg::BIT_COUNTDOWN_FLAG])
      else $error("writing zero did not clear");
   a_flag_and_write: assert property (wr_flags && !match_rise
      |=> match_event_flag == ($past(match_event_flag)
      && $past(reg_wdata[rtcam_pkg::BIT_MATCH_FLAG])))
      else $error("flag write did not combine by and");
   a_none_enabled: assert property (!any_enabled && !match_event_flag
      |=> !match_event_flag)
      else $error("flag set with all fields disabled");
   a_minute_mismatch: assert property (!minute_match_disable
      && !field_eq(minute_match_reg_ff, cur_minute, rtcam_pkg::CMP_MINUTE) |-> !match_now)
      else $error("minute mismatch still matched");
   a_meridiem_split: assert property (hour_mode_12 && !hour_match_disable
      && (hour_match_reg_ff[5] != cur_hour[5]) |-> !match_now)
      else $error("alarm matched across noon");
   a_unused_zero: assert property (hour_match_reg_ff[6] == 1'b0
      && day_match_reg_ff[6] == 1'b0 && weekday_match_reg_ff[6:3] == 4'h0
      && square_wave_select_ff[7:3] == 5'h00)
      else $error("unused bit stored");
   a_minute_lands: assert property (hit(reg_wr, reg_addr, rtcam_pkg::OFS_MINUTE_MATCH)
      |=> minute_match_reg_ff == $past(reg_wdata))
      else $error("minute match write lost");
   a_read_back: assert property (reg_addr == rtcam_pkg::OFS_HOUR_MATCH && !reg_wr
      |=> reg_rdata == $past(hour_match_reg_ff))
      else $error("hour match read wrong");
   a_disabled_ignored: assert property (minute_match_disable && !hour_match_disable
      && day_match_disable && weekday_match_disable
      && field_eq(hour_match_reg_ff, cur_hour, hour_cmp_mask(hour_mode_12))
      |-> match_now)
      else $error("disabled field took part");

   // Main scenarios
   c_alarm_irq: cover property (match_rise ##1 irq_n_oe);
   c_flag_clear: cover property (match_event_flag ##1 !match_event_flag);
   c_set_with_clear: cover property (match_rise && wr_flags);
   c_twelve_hour: cover property (hour_mode_12 && match_rise && !hour_match_disable);

endmodule

// *** rtcam_pkg.sv ***
package rtcam_pkg;

   // Register offsets
   localparam logic [7:0] OFS_EVENT_FLAGS = 8'h01;
   localparam logic [7:0] OFS_MINUTE_MATCH = 8'h09;
   localparam logic [7:0] OFS_HOUR_MATCH = 8'h0a;
   localparam logic [7:0] OFS_DAY_MATCH = 8'h0b;
   localparam logic [7:0] OFS_WEEKDAY_MATCH = 8'h0c;
   localparam logic [7:0] OFS_SQUARE_WAVE = 8'h0d;

   // Field positions
   localparam int BIT_FIELD_DISABLE = 7;
   localparam int BIT_TICK_FLAG = 5;
   localparam int BIT_MATCH_FLAG = 3;
   localparam int BIT_COUNTDOWN_FLAG = 2;
   localparam int BIT_MATCH_IRQ_EN = 1;

   // Storage masks, unused bits read as zero; MASK_FLAGS marks the flag bits, other flag register bits are stored as written
   localparam logic [7:0] MASK_MINUTE = 8'hff;
   localparam logic [7:0] MASK_HOUR = 8'hbf;
   localparam logic [7:0] MASK_DAY = 8'hbf;
   localparam logic [7:0] MASK_WEEKDAY = 8'h87;
   localparam logic [7:0] MASK_SQUARE_WAVE = 8'h07;
   localparam logic [7:0] MASK_FLAGS = 8'h2c;

   // Comparison masks over the value bits
   localparam logic [7:0] CMP_MINUTE = 8'h7f;
   localparam logic [7:0] CMP_HOUR_12 = 8'h3f;
   localparam logic [7:0] CMP_HOUR_24 = 8'h3f;
   localparam logic [7:0] CMP_DAY = 8'h3f;
   localparam logic [7:0] CMP_WEEKDAY = 8'h07;

   // Reset values
   localparam logic [7:0] RST_MATCH = 8'h80;
   localparam logic [7:0] RST_SQUARE_WAVE = 8'h00;
   localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;

   // Square wave codes
   localparam logic [2:0] CODE_32768 = 3'h0;
   localparam logic [2:0] CODE_16384 = 3'h1;
   localparam logic [2:0] CODE_8192 = 3'h2;
   localparam logic [2:0] CODE_4096 = 3'h3;
   localparam logic [2:0] CODE_2048 = 3'h4;
   localparam logic [2:0] CODE_1024 = 3'h5;
   localparam logic [2:0] CODE_1HZ = 3'h6;
   localparam logic [2:0] CODE_LOW = 3'h7;

   // Divider: one count per oscillator half period
   localparam int DIV_W = 16;
   localparam int TAP_1HZ = 15;

endpackage

// *** rtcam_sqw.sv ***
`timescale 1ns/1ps
module rtcam_sqw
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Oscillator half-period pulse and stop
   input wire logic osc_edge,
   input wire logic stop_active,
   // Selected code
   input wire logic [2:0] code,
   // Open-drain pin drive, high pulls low
   output logic pin_oe_ff
);

   logic [rtcam_pkg::DIV_W-1:0] div_ff;
   logic [rtcam_pkg::DIV_W-1:0] nxt_div;
   logic nxt_wave;
   logic nxt_pin_oe;

   // Binary divider taps give exact halves, hence even duty
   always_comb
   begin
      nxt_div = div_ff;
      if (osc_edge)
      begin
         nxt_div = div_ff + 16'h0001;
      end
      case (code)
         rtcam_pkg::CODE_32768: nxt_wave = div_ff[0];
         rtcam_pkg::CODE_16384: nxt_wave = div_ff[1];
         rtcam_pkg::CODE_8192: nxt_wave = div_ff[2];
         rtcam_pkg::CODE_4096: nxt_wave = div_ff[3] & ~stop_active;
         rtcam_pkg::CODE_2048: nxt_wave = div_ff[4] & ~stop_active;
         rtcam_pkg::CODE_1024: nxt_wave = div_ff[5] & ~stop_active;
         rtcam_pkg::CODE_1HZ: nxt_wave = div_ff[rtcam_pkg::TAP_1HZ] & ~stop_active;
         rtcam_pkg::CODE_LOW: nxt_wave = 1'b0;
         default: nxt_wave = 1'b0;
      endcase
      nxt_pin_oe = ~nxt_wave;
   end

   // Reset pulls the pin low until the divider runs
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         div_ff <= '0;
         pin_oe_ff <= 1'b1;
      end
      else
      begin
         div_ff <= nxt_div;
         pin_oe_ff <= nxt_pin_oe;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   a_code_low_pin: assert property (code == rtcam_pkg::CODE_LOW |=> pin_oe_ff)
      else $error("square wave not low for code 7");
   a_stop_low_pin: assert property (stop_active && code >= rtcam_pkg::CODE_4096
      && code <= rtcam_pkg::CODE_1HZ |=> pin_oe_ff)
      else $error("square wave not stopped");
   a_fast_tap_pin: assert property (code == rtcam_pkg::CODE_16384
      |=> pin_oe_ff == !$past(div_ff[1]))
      else $error("16384 tap wrong");
   c_stop_fast: cover property (stop_active && code == rtcam_pkg::CODE_8192 ##1 !pin_oe_ff);

endmodule

// *** rtcam_host.sv ***
`timescale 1ns/1ps
module rtcam_host
(
   // Clock
   input wire logic mclk,
   // Register access towards the device
   output logic reg_wr,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Open-drain interrupt drive
   input wire logic irq_n_oe,
   output logic irq_line
);
   // Interrupt wire has a pull-up
   assign irq_line = irq_n_oe ? 1'b0 : 1'b1;

   // Idle bus at time zero
   initial
   begin
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // One-cycle strobe; data scrambled after so nothing leans on it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask

   // Read data is registered, so sample one cycle later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      @(negedge mclk);
      d = reg_rdata;
   endtask

   // Clear only the match flag, other bits rewritten as read
   task automatic clear_match_flag();
      logic [7:0] v;
      rd(rtcam_pkg::OFS_EVENT_FLAGS, v);
      wr(rtcam_pkg::OFS_EVENT_FLAGS, v & 8'hf7);
   endtask
endmodule

// *** rtc_alarm_and_clock_output_test.sv ***
`timescale 1ns/1ps
module rtc_alarm_and_clock_output_test;
   logic mclk, rstn, hour_mode_12, periodic_tick_set, countdown_event_set;
   logic osc_edge, stop_active;
   logic [7:0] cur_minute, cur_hour, cur_day, cur_weekday, d;
   wire logic reg_wr, irq_n_o, irq_n_oe, sq_o, sq_oe, irq_line, sq_line;
   wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
   int err_total, tests_run, cycles;

   // Square wave wire has a pull-up
   assign sq_line = sq_oe ? 1'b0 : 1'b1;

   rtcam_top rtcam_top_inst (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .cur_minute(cur_minute), .cur_hour(cur_hour), .cur_day(cur_day),
      .cur_weekday(cur_weekday), .hour_mode_12(hour_mode_12),
      .periodic_tick_set(periodic_tick_set), .countdown_event_set(countdown_event_set),
      .osc_edge(osc_edge), .stop_active(stop_active), .irq_n_lvl(irq_n_o),
      .irq_n_oe(irq_n_oe), .square_wave_pin_lvl(sq_o), .square_wave_pin_oe(sq_oe));

   rtcam_host rtcam_host_inst (.mclk(mclk), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_n_oe(irq_n_oe),
      .irq_line(irq_line));

   // Clock and hang guard
   always #2 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         conclude();
      end
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Counts of pin activity allow one cycle of phase slack
   task automatic check_near(input int got, input int exp);
      tests_run++;
      if (got > exp + 1 || got < exp - 1)
      begin
         err_total++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
      rtcam_host_inst.rd(a, d);
      check8(d, exp);
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic clear_flag();
      rtcam_host_inst.clear_match_flag();
   endtask

   task automatic check_reset_values();
      logic [7:0] ofs [7] = '{8'h01, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h02};
      logic [7:0] exp [7] = '{8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00};
      for (int i = 0; i < 7; i++)
         rd_check(ofs[i], exp[i]);
      check8({6'h00, irq_n_o, sq_o}, 8'h00);
   endtask

   // All ones written; unused bits must drop, unmapped write ignored
   task automatic check_unused_bits();
      logic [7:0] ofs [5] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
      logic [7:0] msk [5] = '{8'hff, 8'hbf, 8'hbf, 8'h87, 8'h07};
      rtcam_host_inst.wr(8'h02, 8'hff);
      rd_check(8'h02, 8'h00);
      for (int i = 0; i < 5; i++)
      begin
         rtcam_host_inst.wr(ofs[i], 8'hff);
         rd_check(ofs[i], msk[i]);
         rtcam_host_inst.wr(ofs[i], (i == 4) ? 8'h00 : 8'h80);
      end
   endtask

   task automatic check_flag_writes();
      @(negedge mclk);
      periodic_tick_set = 1'b1;
      countdown_event_set = 1'b1;
      @(negedge mclk);
      periodic_tick_set = 1'b0;
      countdown_event_set = 1'b0;
      rd_check(8'h01, 8'h24);
      rtcam_host_inst.wr(8'h01, 8'h2c);
      rd_check(8'h01, 8'h24);
      rtcam_host_inst.wr(8'h01, 8'h04);
      rd_check(8'h01, 8'h04);
      rtcam_host_inst.wr(8'h01, 8'h00);
   endtask

   task automatic check_alarm_basic();
      rtcam_host_inst.wr(8'h01, 8'h02);
      rtcam_host_inst.wr(8'h09, 8'h15);
      idle(3);
      rd_check(8'h01, 8'h0a);
      check8({7'h00, irq_line}, 8'h00);
      clear_flag();
      idle(3);
      rd_check(8'h01, 8'h02);
      check8({7'h00, irq_line}, 8'h01);
      @(negedge mclk);
      cur_minute = 8'h16;
      idle(2);
      cur_minute = 8'h15;
      idle(3);
      rd_check(8'h01, 8'h0a);
      clear_flag();
      rtcam_host_inst.wr(8'h09, 8'h80);
   endtask

   task automatic check_alarm_fields();
      rtcam_host_inst.wr(8'h0a, 8'ha3);
      rtcam_host_inst.wr(8'h09, 8'h15);
      idle(3);
      rd_check(8'h01, 8'h0a);
      clear_flag();
      rtcam_host_inst.wr(8'h09, 8'h80);
      cur_minute = 8'h16;
      idle(2);
      cur_minute = 8'h15;
      idle(3);
      rd_check(8'h01, 8'h02);
      // PM alarm against an AM time of the same digits
      rtcam_host_inst.wr(8'h0a, 8'h31);
      idle(3);
      rd_check(8'h01, 8'h02);
      cur_hour = 8'h31;
      idle(3);
      rd_check(8'h01, 8'h0a);
      clear_flag();
      rtcam_host_inst.wr(8'h0a, 8'h80);
      hour_mode_12 = 1'b0;
      cur_hour = 8'h23;
      rtcam_host_inst.wr(8'h0a, 8'h23);
      idle(3);
      rd_check(8'h01, 8'h0a);
      clear_flag();
      rtcam_host_inst.wr(8'h0a, 8'h80);
      rtcam_host_inst.wr(8'h0b, 8'h05);
      idle(3);
      rd_check(8'h01, 8'h0a);
      clear_flag();
      rtcam_host_inst.wr(8'h0b, 8'h80);
      rtcam_host_inst.wr(8'h0c, 8'h03);
      idle(3);
      rd_check(8'h01, 8'h0a);
      clear_flag();
      rtcam_host_inst.wr(8'h0c, 8'h80);
   endtask

   task automatic measure(output int tr, output int hi);
      logic prev;
      tr = 0;
      hi = 0;
      prev = sq_line;
      repeat (64)
      begin
         @(negedge mclk);
         tr += (sq_line !== prev);
         hi += (sq_line === 1'b1);
         prev = sq_line;
      end
   endtask

   // Divider steps every cycle, so code c below 6 toggles every 2**c cycles
   task automatic check_square_wave(input logic stop);
      int tr, hi;
      stop_active = stop;
      for (int c = 0; c < 8; c++)
      begin
         rtcam_host_inst.wr(8'h0d, 8'(c));
         idle(4);
         measure(tr, hi);
         if (c == 7 || (stop && c >= 3))
         begin
            check8(8'(tr), 8'h00);
            check8(8'(hi), 8'h00);
            check8({7'h00, sq_line}, 8'h00);
         end
         else if (c < 6)
         begin
            check_near(tr, 64 >> c);
            if (c > 0)
               check_near(hi, 32);
         end
         // One hertz cannot toggle inside a 64-cycle window
         else
            check8(8'(tr), 8'h00);
      end
      stop_active = 1'b0;
   endtask

   initial
   begin
      mclk = 1'b0;
      rstn = 1'b0;
      cur_minute = 8'h15;
      cur_hour = 8'h11;
      cur_day = 8'h05;
      cur_weekday = 8'h03;
      hour_mode_12 = 1'b1;
      periodic_tick_set = 1'b0;
      countdown_event_set = 1'b0;
      osc_edge = 1'b1;
      stop_active = 1'b0;
      err_total = 0;
      tests_run = 0;
      cycles = 0;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      rstn = 1'b1;
      check_reset_values();
      check_unused_bits();
      check_flag_writes();
      check_alarm_basic();
      check_alarm_fields();
      check_square_wave(1'b0);
      check_square_wave(1'b1);
      conclude();
   end
endmodule
